// ---- hw/slt_pkg.sv ----
// Constants, codes and carrier types of the serial link test block
package slt_pkg;
   // ****************************************************
   // Register map and reset values
   // ****************************************************
   localparam logic [9:0] ADDR_TEST_SEL = 10'h205;
   localparam logic [9:0] ADDR_DEV_IDENT = 10'h206;
   localparam logic [9:0] ADDR_FRAME_CHAR = 10'h207;
   localparam logic [9:0] ADDR_LINK_CTRL = 10'h210;
   localparam logic [9:0] ADDR_LINK_STAT = 10'h211;
   localparam logic [7:0] RST_TEST_SEL = 8'h00;
   localparam logic [7:0] RST_DEV_IDENT = 8'h00;
   localparam logic [7:0] RST_FRAME_CHAR = 8'h00;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_MODE8B_BIT = 1;
   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam logic [3:0] ILA_LAST = 4'hF;
   localparam logic [3:0] ILA_DID_POS = 4'h1;
   localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;

   // ****************************************************
   // Test selections, frame characters, states
   // ****************************************************
   typedef enum logic [4:0] {
      TS_NORMAL = 5'h00, TS_PRBS7 = 5'h01, TS_PRBS15 = 5'h02,
      TS_PRBS23 = 5'h03, TS_RAMP = 5'h04, TS_TRANSPORT = 5'h05,
      TS_D215 = 5'h06, TS_K285 = 5'h07, TS_ILA = 5'h08,
      TS_RPAT = 5'h09, TS_LOW = 5'h0A, TS_HIGH = 5'h0B,
      TS_PRBS9 = 5'h0D, TS_PRBS31 = 5'h0E, TS_CLOCK = 5'h0F,
      TS_K287 = 5'h10
   } slt_test_t;
   localparam logic [1:0] FC_K287 = 2'h0;
   localparam logic [1:0] FC_K281 = 2'h1;
   localparam logic [1:0] FC_K285 = 2'h2;
   localparam logic [7:0] K28_0 = 8'h1C;
   localparam logic [7:0] K28_1 = 8'h3C;
   localparam logic [7:0] K28_3 = 8'h7C;
   localparam logic [7:0] K28_4 = 8'h9C;
   localparam logic [7:0] K28_5 = 8'hBC;
   localparam logic [7:0] K28_7 = 8'hFC;
   localparam logic [7:0] D21_5 = 8'hB5;
   localparam logic [15:0] CLOCK_WORD = 16'h00FF;
   // Modified random pattern words, sent in this order and then repeated
   localparam logic [2:0] RPAT_LAST = 3'h5;
   localparam logic [15:0] RPAT_WORD [6] = '{16'hBED7, 16'h2347, 16'h6B8F,
                                            16'hB314, 16'h5EFB, 16'h3559};
   typedef enum logic [2:0] {
      ST_OFF = 3'b001, ST_LOAD = 3'b010, ST_RUN = 3'b100
   } slt_state_t;

   // One lane word: two bytes, each with its control-character flag
   typedef struct packed {
      logic [15:0] data;
      logic [1:0] isK;
   } slt_lane_t;
endpackage

// ---- hw/slt_link_test.sv ----
// Serial link test-pattern generator with frame and identifier settings
//
// Contract
// - Selection zero disables test patterns; normal converter data flows.
// - Selections 1, 2, 3 send PRBS7, PRBS15, PRBS23.
// - Selection 13 sends PRBS9, selection 14 sends PRBS31.
// - Selections 4, 5, 6 send ramp, transport test, continuous D21.5.
// - Selections 7, 8, 9, 16 work only in 8b/10b link modes.
// - Selection 8 repeats lane alignment; 9 sends modified random pattern.
// - Selection 10 holds lanes low, 11 holds them high.
// - Selection 15 sends eight zeros then eight ones repeatedly.
// - The identifier goes out in the second alignment multiframe.
// - Link A sends the identifier, link B the identifier plus one.
// - Identifier bit zero is ignored and reads back as zero.
// - Two-bit field picks the frame-end comma, 8b/10b modes only.
// - Frame-end codes: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.

// ****************************************************
// Sample FIFO
// ****************************************************
module slt_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_r;
   logic [AW:0] rdPtr_r;
   logic doWr;
   logic doRd;

   // Full when pointers differ only in the wrap bit
   assign inReady = (wrPtr_r ^ rdPtr_r) != {1'b1, {AW{1'b0}}};
   assign outValid = wrPtr_r != rdPtr_r;
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;
   assign outData = mem[rdPtr_r[AW-1:0]];

   // Storage, no reset needed on data
   always_ff @(posedge mclk) begin
      if (doWr) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   // Pointers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (doWr) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (doRd) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end
endmodule

// ****************************************************
// Link test top
// ****************************************************
module slt_link_test
   import slt_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [9:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic [DATA_W-1:0] sampleData,
   input wire logic sampleValid,
   output logic sampleReady,
   output slt_lane_t laneOut [2],
   output logic laneValid,
   input wire logic laneReady,
   output logic [7:0] linkAIdent,
   output logic [7:0] linkBIdent
);
   logic [4:0] testSel_r;
   logic [7:0] devIdent_r;
   logic [1:0] frameCharSel_r;
   logic serialLinkEnable_r;
   logic linkModeIs8b_r;
   slt_state_t state_r;
   slt_test_t activeSel_r;
   logic [1:0] activeFchar_r;
   logic active8b_r;
   logic [30:0] prbs_r;
   logic [15:0] rampCnt_r;
   logic [3:0] ilaWord_r;
   logic [1:0] ilaMf_r;
   logic [2:0] rpatIdx_r;
   logic [7:0] prevLow_r;
   logic [DATA_W-1:0] fifoData;
   logic fifoValid;
   logic fifoPop;
   logic running;
   logic advance;
   logic [7:0] frameChar;
   slt_lane_t pattern;
   logic didSlot;

   // ****************************************************
   // Register bus
   // ****************************************************
   // Settings writes, frozen copies below protect a running link
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         testSel_r <= RST_TEST_SEL[4:0];
         devIdent_r <= RST_DEV_IDENT;
         frameCharSel_r <= RST_FRAME_CHAR[1:0];
         serialLinkEnable_r <= 1'b0;
         linkModeIs8b_r <= 1'b1;
      end else if (regWr) begin
         case (regAddr)
            ADDR_TEST_SEL: testSel_r <= regWrData[4:0];
            ADDR_DEV_IDENT: devIdent_r <= {regWrData[7:1], 1'b0};
            ADDR_FRAME_CHAR: frameCharSel_r <= regWrData[1:0];
            ADDR_LINK_CTRL: begin
               serialLinkEnable_r <= regWrData[CTRL_ENABLE_BIT];
               linkModeIs8b_r <= regWrData[CTRL_MODE8B_BIT];
            end
            default: ;
         endcase
      end
   end

   // Read data stands one cycle after the strobe, zero when unmapped
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ADDR_TEST_SEL: regRdData <= {3'h0, testSel_r};
            ADDR_DEV_IDENT: regRdData <= devIdent_r;
            ADDR_FRAME_CHAR: regRdData <= {6'h00, frameCharSel_r};
            ADDR_LINK_CTRL: regRdData <= {6'h00, linkModeIs8b_r,
                                          serialLinkEnable_r};
            ADDR_LINK_STAT: regRdData <= {active8b_r, activeFchar_r,
                                          activeSel_r};
            default: regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   // ****************************************************
   // Link enable sequencing
   // ****************************************************
   // Settings are captured only in the load cycle after enabling
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= ST_OFF;
      end else begin
         case (state_r)
            ST_OFF: if (serialLinkEnable_r) state_r <= ST_LOAD;
            ST_LOAD: state_r <= ST_RUN;
            ST_RUN: if (!serialLinkEnable_r) state_r <= ST_OFF;
            default: state_r <= ST_OFF;
         endcase
      end
   end

   // Frozen copies of the settings for the running link
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         activeSel_r <= TS_NORMAL;
         activeFchar_r <= FC_K287;
         active8b_r <= 1'b1;
         linkAIdent <= 8'h00;
         linkBIdent <= 8'h01;
      end else if (state_r == ST_LOAD) begin
         activeSel_r <= slt_test_t'(testSel_r);
         activeFchar_r <= frameCharSel_r;
         active8b_r <= linkModeIs8b_r;
         linkAIdent <= devIdent_r;
         linkBIdent <= devIdent_r + 8'h01;
      end
   end

   assign running = state_r == ST_RUN;
   assign laneValid = running;
   assign advance = running && laneReady;
   assign fifoPop = advance && activeSel_r == TS_NORMAL;

   slt_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_slt_fifo (
      .mclk(mclk),
      .rst(rst),
      .inData(sampleData),
      .inValid(sampleValid),
      .inReady(sampleReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(fifoPop)
   );

   // ****************************************************
   // Pattern sources
   // ****************************************************
   // Sixteen Fibonacci shifts per word; taps follow the chosen order
   function automatic logic [30:0] prbsNext(input logic [30:0] s,
                                           input slt_test_t sel);
      logic [30:0] v;
      logic nb;
      v = s;
      for (int i = 0; i < 16; i++) begin
         case (sel)
            TS_PRBS7: nb = v[6] ^ v[5];
            TS_PRBS9: nb = v[8] ^ v[4];
            TS_PRBS15: nb = v[14] ^ v[13];
            TS_PRBS23: nb = v[22] ^ v[17];
            default: nb = v[30] ^ v[27];
         endcase
         v = {v[29:0], nb};
      end
      return v;
   endfunction

   // Sequencers restart on every load
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prbs_r <= PRBS_SEED;
         rampCnt_r <= 16'h0000;
         ilaWord_r <= 4'h0;
         ilaMf_r <= 2'h0;
         rpatIdx_r <= 3'h0;
      end else if (state_r == ST_LOAD) begin
         prbs_r <= PRBS_SEED;
         rampCnt_r <= 16'h0000;
         ilaWord_r <= 4'h0;
         ilaMf_r <= 2'h0;
         rpatIdx_r <= 3'h0;
      end else if (advance) begin
         prbs_r <= prbsNext(prbs_r, activeSel_r);
         rampCnt_r <= rampCnt_r + 16'h0001;
         ilaWord_r <= ilaWord_r + 4'h1;
         if (ilaWord_r == ILA_LAST) begin
            ilaMf_r <= ilaMf_r + 2'h1;
         end
         rpatIdx_r <= (rpatIdx_r == RPAT_LAST) ? 3'h0 : rpatIdx_r + 3'h1;
      end
   end

   // Last raw low byte, for repeat detection at frame end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prevLow_r <= 8'h00;
      end else if (fifoPop && fifoValid) begin
         prevLow_r <= fifoData[7:0];
      end
   end

   // Frame-end comma; reserved code falls back to the compliant one
   assign frameChar = (activeFchar_r == FC_K281) ? K28_1 :
                      (activeFchar_r == FC_K285) ? K28_5 : K28_7;

   // Word for the selected source; 8b/10b-only modes send zeros otherwise
   always_comb begin
      pattern = '{data: 16'h0000, isK: 2'b00};
      didSlot = 1'b0;
      case (activeSel_r)
         TS_NORMAL: begin
            if (fifoValid) begin
               pattern.data = fifoData;
               if (active8b_r && fifoData[7:0] == prevLow_r) begin
                  pattern.data[7:0] = frameChar;
                  pattern.isK[0] = 1'b1;
               end
            end
         end
         TS_PRBS7, TS_PRBS15, TS_PRBS23, TS_PRBS9, TS_PRBS31:
            pattern.data = prbs_r[15:0];
         TS_RAMP: pattern.data = rampCnt_r;
         TS_TRANSPORT: pattern.data = {rampCnt_r[11:0], 4'h0};
         TS_D215: pattern.data = {D21_5, D21_5};
         TS_K285, TS_K287: begin
            if (active8b_r) begin
               pattern.data = (activeSel_r == TS_K285) ?
                  {K28_5, K28_5} : {K28_7, K28_7};
               pattern.isK = 2'b11;
            end
         end
         TS_ILA: begin
            if (active8b_r) begin
               if (ilaWord_r == 4'h0) begin
                  pattern = '{data: {K28_0, 8'h00}, isK: 2'b10};
               end else if (ilaWord_r == ILA_LAST) begin
                  pattern = '{data: {8'h00, K28_3}, isK: 2'b01};
               end else if (ilaMf_r == 2'h1 && ilaWord_r == ILA_DID_POS) begin
                  pattern = '{data: {K28_4, 8'h00}, isK: 2'b10};
                  didSlot = 1'b1;
               end else begin
                  pattern.data = {ilaWord_r, 4'h0, ilaWord_r, 4'h0};
               end
            end
         end
         TS_RPAT: begin
            if (active8b_r) begin
               pattern.data = RPAT_WORD[rpatIdx_r];
            end
         end
         TS_LOW: pattern.data = 16'h0000;
         TS_HIGH: pattern.data = 16'hFFFF;
         TS_CLOCK: pattern.data = CLOCK_WORD;
         default: pattern.data = 16'h0000;
      endcase
   end

   // ****************************************************
   // Lane output registers
   // ****************************************************
   // Each link takes the shared word and inserts its own identifier
   for (genvar g = 0; g < 2; g++) begin : gLane
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            laneOut[g] <= '0;
         end else if (!running) begin
            laneOut[g] <= '0;
         end else if (laneReady) begin
            laneOut[g] <= pattern;
            if (didSlot) begin
               laneOut[g].data[7:0] <= (g == 0) ? linkAIdent :
                                       linkBIdent;
            end
         end
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence armSeq;
      state_r == ST_OFF && serialLinkEnable_r;
   endsequence
   sequence loadSeq;
      state_r == ST_LOAD ##1 state_r == ST_RUN;
   endsequence

   normal_data_a: assert property (
      advance && activeSel_r == TS_NORMAL && fifoValid && !active8b_r
      |=> laneOut[0].data == $past(fifoData))
      else $error("normal data not forwarded");
   prbs_moves_a: assert property (
      advance && activeSel_r == TS_PRBS7 |=> prbs_r != $past(prbs_r))
      else $error("prbs state stuck");
   ramp_step_a: assert property (
      advance && activeSel_r == TS_RAMP ##1 advance
      |=> laneOut[0].data == $past(laneOut[0].data) + 16'h0001)
      else $error("ramp step wrong");
   comma_gate_a: assert property (
      advance && activeSel_r == TS_K287 && !active8b_r
      |=> laneOut[0].data == 16'h0000)
      else $error("comma sent outside 8b10b");
   held_level_a: assert property (
      advance && activeSel_r == TS_HIGH |=> laneOut[1].data == 16'hFFFF)
      else $error("lane not held high");
   clock_word_a: assert property (
      advance && activeSel_r == TS_CLOCK |=> laneOut[0].data == 16'h00FF)
      else $error("clock pattern wrong");
   ident_slot_a: assert property (
      advance && didSlot |=> laneOut[0].data[7:0] == linkAIdent
      && laneOut[1].data[7:0] == linkAIdent + 8'h01)
      else $error("identifier slot wrong");
   ident_even_a: assert property (
      regRd && regAddr == ADDR_DEV_IDENT |=> regRdData[0] == 1'b0)
      else $error("identifier bit zero set");
   frame_char_a: assert property (
      advance && pattern.isK[0] && activeSel_r == TS_NORMAL
      && activeFchar_r == FC_K285 |=> laneOut[0].data[7:0] == 8'hBC)
      else $error("frame char mismatch");
   settings_load_a: assert property (
      armSeq |=> loadSeq and ##1 activeSel_r == $past(testSel_r))
      else $error("settings not loaded on enable");
endmodule

// ---- verification/slt_rx_model.sv ----
// Lane receiver model: takes lane words, optionally with random back-pressure
module slt_rx_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic stallOn,
   output logic laneReady
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************
   // Back-pressure
   // ****************************************************
   // Ready moves only after an edge; random gaps mimic a busy receiver
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         laneReady <= 1'b0;
      end else begin
         laneReady <= stallOn ? 1'($urandom_range(0, 1)) : 1'b1;
      end
   end
endmodule

// ---- verification/slt_link_test_tb_top.sv ----
// Self-checking bench of the serial link test-pattern block
module slt_link_test_tb_top;
   import slt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************
   // Signals and notes
   // ****************************************************
   logic mclk, rst, regWr, regRd, sampleValid, sampleReady;
   logic laneValid, laneReady, stallOn, rdHit, accHit, ok, m8;
   logic [9:0] regAddr;
   logic [7:0] regWrData, regRdData, linkAIdent, linkBIdent;
   logic [7:0] fcCur, id, ch;
   logic [15:0] sampleData, d;
   logic [30:0] st;
   logic [36:0] e;
   slt_test_t s;
   slt_lane_t laneOut [2];
   logic [36:0] laneQ [$];
   logic [7:0] rdQ [$];
   int num_errors, comparisons, tn, tm, n, cnt;

   slt_link_test u_slt_link_test (.mclk(mclk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .sampleData(sampleData),
      .sampleValid(sampleValid), .sampleReady(sampleReady),
      .laneOut(laneOut), .laneValid(laneValid), .laneReady(laneReady),
      .linkAIdent(linkAIdent), .linkBIdent(linkBIdent));
   slt_rx_model u_slt_rx_model (.mclk(mclk), .rst(rst), .stallOn(stallOn),
      .laneReady(laneReady));

   // Free-running 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ****************************************************
   // Helpers
   // ****************************************************
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] v);
      @(posedge mclk);
      rdQ.push_back(v);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
   endtask

   // Offers one sample; ok tells whether the FIFO could take it
   task automatic put(input logic [15:0] v, output logic okOut);
      @(posedge mclk);
      sampleData <= v;
      sampleValid <= 1'b1;
      @(negedge mclk);
      okOut = sampleReady;
   endtask

   // Waits for all noted words, then turns the link off again
   task automatic drain(input logic mode);
      for (int t = 0; t < 4000 && laneQ.size() > 0; t++) begin
         @(posedge mclk);
      end
      if (laneQ.size() > 0) begin
         num_errors++;
         $display("[ERR] %0t lane words missing", $time);
         report_and_stop();
      end
      wr(ADDR_LINK_CTRL, {6'h00, mode, 1'b0});
      repeat (3) @(posedge mclk);
      check({35'h0, laneValid}, 36'h0);
   endtask

   // Expected word pair {lane B, lane A} for the fixed patterns
   function automatic logic [35:0] pat(input slt_test_t p, input int k,
                                       input logic mode);
      logic [15:0] rp [6] = '{16'hBED7, 16'h2347, 16'h6B8F, 16'hB314,
                              16'h5EFB, 16'h3559};
      logic [15:0] v;
      logic [1:0] q;
      logic [3:0] w;
      v = 16'h0000;
      q = 2'b00;
      w = 4'(k);
      if (!mode && (p inside {TS_K285, TS_ILA, TS_RPAT, TS_K287})) begin
         return 36'h0;
      end
      case (p)
         TS_RAMP: v = 16'(k);
         TS_TRANSPORT: v = {12'(k), 4'h0};
         TS_D215: v = {D21_5, D21_5};
         TS_K285: v = {K28_5, K28_5};
         TS_K287: v = {K28_7, K28_7};
         TS_RPAT: v = rp[k % 6];
         TS_HIGH: v = 16'hFFFF;
         TS_CLOCK: v = CLOCK_WORD;
         TS_ILA: v = {w, 4'h0, w, 4'h0};
         default: v = 16'h0000;
      endcase
      if (p == TS_K285 || p == TS_K287) begin
         q = 2'b11;
      end
      if (p == TS_ILA && w == 4'h0) begin
         v = {K28_0, 8'h00};
         q = 2'b10;
      end
      if (p == TS_ILA && w == ILA_LAST) begin
         v = {8'h00, K28_3};
         q = 2'b01;
      end
      if (p == TS_ILA && k == 16 + int'(ILA_DID_POS)) begin
         return {K28_4, id, 2'b10, K28_4, id & 8'hFE, 2'b10};
      end
      return {v, q, v, q};
   endfunction

   // ****************************************************
   // Output watcher
   // ****************************************************
   // Each answer is matched with the oldest note once the edge has settled
   always @(posedge mclk) begin
      rdHit = regRd;
      accHit = laneValid && laneReady;
      #1;
      if (rdHit && rdQ.size() > 0) begin
         check({28'h0, regRdData}, {28'h0, rdQ.pop_front()});
      end else if (!rst) begin
         check({28'h0, regRdData}, 36'h0);
      end
      if (accHit && laneQ.size() > 0) begin
         e = laneQ.pop_front();
         check(e[36] ? {18'h0, laneOut[0]} : {laneOut[1], laneOut[0]},
               e[35:0]);
      end
   end

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      rst = 1'b1;
      regAddr = 10'h000;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      sampleData = 16'h0000;
      sampleValid = 1'b0;
      stallOn = 1'b0;
      num_errors = 0;
      comparisons = 0;
      void'($urandom(5));
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd(ADDR_TEST_SEL, RST_TEST_SEL);
      rd(ADDR_DEV_IDENT, RST_DEV_IDENT);
      rd(ADDR_FRAME_CHAR, RST_FRAME_CHAR);
      rd(ADDR_LINK_CTRL, 8'h02);
      id = 8'($urandom()) | 8'h01;
      wr(ADDR_DEV_IDENT, id);
      rd(ADDR_DEV_IDENT, id & 8'hFE);
      wr(ADDR_TEST_SEL, 8'hFF);
      rd(ADDR_TEST_SEL, 8'h1F);
      wr(ADDR_FRAME_CHAR, 8'hFF);
      rd(ADDR_FRAME_CHAR, 8'h03);
      wr(10'h3FF, 8'hA5);
      rd(10'h3FF, 8'h00);
      // Selection codes 1 to 16, then the 8b/10b-only codes in 64b/66b mode
      for (int i = 1; i < 21; i++) begin
         s = slt_test_t'(i < 17 ? i : (i == 20 ? 16 : i - 10));
         m8 = (i < 17);
         stallOn <= i[0];
         wr(ADDR_TEST_SEL, {3'h0, s});
         n = (s == TS_ILA) ? 32 : 12;
         tn = 0;
         tm = 0;
         case (s)
            TS_PRBS7: {tn, tm} = {32'd7, 32'd6};
            TS_PRBS15: {tn, tm} = {32'd15, 32'd14};
            TS_PRBS23: {tn, tm} = {32'd23, 32'd18};
            TS_PRBS9: {tn, tm} = {32'd9, 32'd5};
            TS_PRBS31: {tn, tm} = {32'd31, 32'd28};
            default: tn = 0;
         endcase
         // First word is the seed itself, then sixteen shifts per word
         st = PRBS_SEED;
         for (int k = 0; k < n; k++) begin
            if (tn != 0) begin
               laneQ.push_back({1'b0, st[15:0], 2'b00, st[15:0], 2'b00});
               repeat (16) st = {st[29:0], st[tn-1] ^ st[tm-1]};
            end else begin
               laneQ.push_back({1'b0, pat(s, k, m8)});
            end
         end
         wr(ADDR_LINK_CTRL, {6'h00, m8, 1'b1});
         drain(m8);
         if (s == TS_ILA) begin
            check({20'h0, linkBIdent, linkAIdent},
                  {20'h0, id, id & 8'hFE});
         end
      end
      // Fill the FIFO until it refuses, then drain it under back-pressure
      stallOn <= 1'b1;
      wr(ADDR_TEST_SEL, 8'h00);
      cnt = 0;
      ok = 1'b1;
      for (int t = 0; t < 40 && ok; t++) begin
         d = 16'($urandom()) | 16'h0080; // Clear of the frame-test bytes
         put(d, ok);
         if (ok) begin
            cnt++;
            laneQ.push_back({1'b1, 18'h0, d, 2'b00});
         end
      end
      @(posedge mclk);
      sampleValid <= 1'b0;
      check(36'(cnt), 36'h10);
      laneQ.push_back({1'b1, 36'h0});
      laneQ.push_back({1'b1, 36'h0});
      wr(ADDR_LINK_CTRL, 8'h01);
      drain(1'b0);
      // Frame-end comma on a repeated low byte, each code, then 64b/66b
      for (int c = 0; c < 5; c++) begin
         fcCur = 8'(c < 4 ? c : 1);
         m8 = (c < 4);
         ch = (fcCur == 8'h01) ? K28_1 : (fcCur == 8'h02) ? K28_5 : K28_7;
         wr(ADDR_FRAME_CHAR, fcCur);
         d = {8'h22, 8'h20 + 8'(c)}; // Fresh low byte, no match with last pass
         put({8'h11, d[7:0]}, ok);
         put(d, ok);
         @(posedge mclk);
         sampleValid <= 1'b0;
         laneQ.push_back({1'b1, 18'h0, 8'h11, d[7:0], 2'b00});
         laneQ.push_back(m8 ? {1'b1, 18'h0, 8'h22, ch, 2'b01} :
                         {1'b1, 18'h0, d, 2'b00});
         wr(ADDR_LINK_CTRL, {6'h00, m8, 1'b1});
         drain(m8);
      end
      // A selection written mid-run waits for the next enable
      stallOn <= 1'b0;
      wr(ADDR_TEST_SEL, {3'h0, TS_CLOCK});
      repeat (40) laneQ.push_back({1'b0, CLOCK_WORD, 2'b00, CLOCK_WORD, 2'b00});
      wr(ADDR_LINK_CTRL, 8'h03);
      repeat (10) @(posedge mclk);
      wr(ADDR_TEST_SEL, {3'h0, TS_HIGH});
      rd(ADDR_LINK_STAT, {1'b1, fcCur[1:0], TS_CLOCK});
      drain(1'b1);
      repeat (6) laneQ.push_back({1'b0, 16'hFFFF, 2'b00, 16'hFFFF, 2'b00});
      wr(ADDR_LINK_CTRL, 8'h03);
      drain(1'b1);
      report_and_stop();
   end
endmodule
